// ==== src/hardware_return_stack.sv ====
// hardware return-address stack for the 8-bit core
// assumes the sequencer never pushes and pops in the same cycle
//
// Function
// R1: sixteen entries of fifteen bits, separate storage
// R2: call, call via w, interrupt push pc
// R3: plain, literal, interrupt returns pop pc
// R4: pc high latch untouched by push/pop
// R5: fault reset off: pushes wrap around circularly
// R6: overflow/underflow flags set regardless of mode
// R7: pointer selects entry seen through top registers
// R8: five-bit pointer detects overflow and underflow
// R9: push increments then writes; pop reads then decrements
// R10: reset leaves stack empty, pointer 0x1f
// R11: empty with fault reset on: top reads zero
// R12: empty with fault reset off: reads entry 15
// R13: fault reset on: overflow/underflow resets, sets flag
// R14: software takes care moving pointer with interrupts
// R15: flags survive stack reset until software clears
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
module hardware_return_stack #(
  parameter int DEPTH = rstack_pkg::DEPTH
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire logic                          i_stack_fault_reset_enable,
  input  wire logic                          i_call,
  input  wire logic                          i_call_via_w,
  input  wire logic                          i_int_vector,
  input  wire logic [rstack_pkg::PC_W-1:0]   i_pc,
  input  wire logic                          i_return,
  input  wire logic                          i_return_with_literal,
  input  wire logic                          i_return_from_interrupt,
  input  wire logic [rstack_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [rstack_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [rstack_pkg::DATA_W-1:0] o_rdata,
  output logic      [rstack_pkg::PC_W-1:0]   o_ret_pc,
  output logic                               o_ret_valid,
  output logic                               o_stack_fault_reset
);
  localparam int PC_W  = rstack_pkg::PC_W;
  localparam int LO_W  = rstack_pkg::LO_W;
  localparam int SP_W  = rstack_pkg::SP_W;
  localparam int IDX_W = rstack_pkg::IDX_W;
  localparam int DW    = rstack_pkg::DATA_W;

  logic [SP_W-1:0]  stack_pointer_r;
  logic [SP_W-1:0]  stack_pointer_nxt;
  logic             ovf_r;
  logic             ovf_nxt;
  logic             unf_r;
  logic             unf_nxt;
  logic [PC_W-1:0]  ret_pc_r;
  logic [PC_W-1:0]  ret_pc_nxt;
  logic             ret_valid_r;
  logic             ret_valid_nxt;
  logic             fault_rst_r;
  logic             fault_rst_nxt;
  logic [DW-1:0]    rdata_r;
  logic [DW-1:0]    rdata_nxt;

  logic             push;
  logic             pop;
  logic             is_empty;
  logic             is_full;
  logic [PC_W-1:0]  mem_rd;
  logic [PC_W-1:0]  top_val;
  logic             mem_wr_lo;
  logic             mem_wr_hi;
  logic [IDX_W-1:0] mem_wr_idx;
  logic [PC_W-1:0]  mem_wr_data;
  logic             wr_sp;
  logic             wr_lo;
  logic             wr_hi;
  logic             wr_flags;

  // request decode; a push shadows a simultaneous pop
  assign push     = i_call | i_call_via_w | i_int_vector; // R2
  assign pop      = (i_return | i_return_with_literal
                    | i_return_from_interrupt) & ~push; // R3
  assign is_empty = (stack_pointer_r == rstack_pkg::SP_EMPTY);
  assign is_full  = (stack_pointer_r == rstack_pkg::SP_FULL); // R8
  assign wr_sp    = i_wr & (i_addr == rstack_pkg::ADR_SP);
  assign wr_lo    = i_wr & (i_addr == rstack_pkg::ADR_TOP_LO);
  assign wr_hi    = i_wr & (i_addr == rstack_pkg::ADR_TOP_HI);
  assign wr_flags = i_wr & (i_addr == rstack_pkg::ADR_STATUS);

  // top of stack as software and returns see it
  always_comb begin
    top_val = mem_rd; // R12
    if (is_empty && i_stack_fault_reset_enable) begin
      top_val = rstack_pkg::PC_ZERO; // R11
    end
  end

  // storage write port: a push owns it, otherwise software byte writes
  always_comb begin
    mem_wr_lo   = 1'b0;
    mem_wr_hi   = 1'b0;
    mem_wr_idx  = stack_pointer_r[IDX_W-1:0]; // R7
    mem_wr_data = {i_wdata[PC_W-LO_W-1:0], i_wdata};
    if (push) begin
      // entry written is the one the pointer moves to
      mem_wr_idx  = stack_pointer_r[IDX_W-1:0] + rstack_pkg::IDX_ONE; // R9
      mem_wr_data = i_pc;
      mem_wr_lo   = ~(is_full && i_stack_fault_reset_enable); // R5
      mem_wr_hi   = ~(is_full && i_stack_fault_reset_enable);
    end else begin
      mem_wr_lo = wr_lo; // R7
      mem_wr_hi = wr_hi;
    end
  end

  stack_mem #(
    .DEPTH (DEPTH),
    .WIDTH (PC_W),
    .LO_W  (LO_W),
    .IDX_W (IDX_W)
  ) u_mem (
    .i_mclk    (i_mclk),
    .i_wr_lo   (mem_wr_lo),
    .i_wr_hi   (mem_wr_hi),
    .i_wr_idx  (mem_wr_idx),
    .i_wr_data (mem_wr_data),
    .i_rd_idx  (stack_pointer_r[IDX_W-1:0]),
    .o_rd_data (mem_rd)
  ); // R1

  // pointer, flags and return path; nothing here reaches pc high latch
  always_comb begin
    stack_pointer_nxt = stack_pointer_r;
    ovf_nxt           = ovf_r;
    unf_nxt           = unf_r;
    ret_pc_nxt        = ret_pc_r;
    ret_valid_nxt     = 1'b0;
    fault_rst_nxt     = 1'b0; // R4
    // software clear first so a same-cycle event wins
    if (wr_flags) begin
      ovf_nxt = ovf_r & i_wdata[rstack_pkg::OVF_BIT];
      unf_nxt = unf_r & i_wdata[rstack_pkg::UNF_BIT]; // R15
    end
    // a careless pointer write may be overtaken by an interrupt push
    if (wr_sp) begin
      stack_pointer_nxt = i_wdata[SP_W-1:0]; // R7 R14
    end
    if (push) begin
      if (is_full) begin
        ovf_nxt = 1'b1; // R6
        if (i_stack_fault_reset_enable) begin
          stack_pointer_nxt = rstack_pkg::SP_EMPTY; // R13
          fault_rst_nxt     = 1'b1;
        end else begin
          // low index rolls over so entry zero is replaced
          stack_pointer_nxt = {1'b0, stack_pointer_r[IDX_W-1:0] + rstack_pkg::IDX_ONE}; // R5
        end
      end else begin
        stack_pointer_nxt = stack_pointer_r + rstack_pkg::SP_ONE; // R9
      end
    end else if (pop) begin
      if (is_empty) begin
        unf_nxt = 1'b1; // R6
        if (i_stack_fault_reset_enable) begin
          stack_pointer_nxt = rstack_pkg::SP_EMPTY; // R13
          fault_rst_nxt     = 1'b1;
        end else begin
          // empty pop hands back entry 15 and wraps below it
          ret_pc_nxt        = top_val; // R12
          ret_valid_nxt     = 1'b1;
          stack_pointer_nxt = {1'b0, stack_pointer_r[IDX_W-1:0] - rstack_pkg::IDX_ONE};
        end
      end else begin
        ret_pc_nxt        = top_val; // R9
        ret_valid_nxt     = 1'b1;
        stack_pointer_nxt = stack_pointer_r - rstack_pkg::SP_ONE; // R9
      end
    end
  end

  // register port read: data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = rstack_pkg::BYTE_ZERO;
    if (i_rd) begin
      case (i_addr)
        rstack_pkg::ADR_SP: begin
          rdata_nxt[SP_W-1:0] = stack_pointer_r;
        end
        rstack_pkg::ADR_TOP_LO: begin
          rdata_nxt = top_val[LO_W-1:0]; // R11 R12
        end
        rstack_pkg::ADR_TOP_HI: begin
          rdata_nxt[PC_W-LO_W-1:0] = top_val[PC_W-1:LO_W];
        end
        rstack_pkg::ADR_STATUS: begin
          rdata_nxt[rstack_pkg::OVF_BIT] = ovf_r;
          rdata_nxt[rstack_pkg::UNF_BIT] = unf_r;
        end
        default: begin
          rdata_nxt = rstack_pkg::BYTE_ZERO; // unmapped reads zero
        end
      endcase
    end
  end

  // the fault reset clears the pointer only, so flags keep the cause
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      stack_pointer_r <= rstack_pkg::SP_EMPTY; // R10
      ovf_r           <= 1'b0;
      unf_r           <= 1'b0;
      ret_pc_r        <= rstack_pkg::PC_ZERO;
      ret_valid_r     <= 1'b0;
      fault_rst_r     <= 1'b0;
      rdata_r         <= rstack_pkg::BYTE_ZERO;
    end else begin
      stack_pointer_r <= stack_pointer_nxt;
      ovf_r           <= ovf_nxt;
      unf_r           <= unf_nxt;
      ret_pc_r        <= ret_pc_nxt;
      ret_valid_r     <= ret_valid_nxt;
      fault_rst_r     <= fault_rst_nxt;
      rdata_r         <= rdata_nxt;
    end
  end

  assign o_rdata             = rdata_r;
  assign o_ret_pc            = ret_pc_r;
  assign o_ret_valid         = ret_valid_r;
  assign o_stack_fault_reset = fault_rst_r;

  // checks on pointer, flags and read paths
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  push_incr_a: assert property ( // R9
    push && !is_full |=> stack_pointer_r == $past(stack_pointer_r) + 5'h01)
    else $error("push did not advance pointer by one");

  pop_value_a: assert property ( // R3
    pop && !is_empty |=> o_ret_valid && o_ret_pc == $past(mem_rd)
                         && stack_pointer_r == $past(stack_pointer_r) - 5'h01)
    else $error("pop returned wrong value or pointer");

  wrap_push_a: assert property ( // R5
    push && is_full && !i_stack_fault_reset_enable
    |=> stack_pointer_r == 5'h00 && ovf_r && !o_stack_fault_reset)
    else $error("full push did not wrap to entry zero");

  ovf_fault_a: assert property ( // R13
    push && is_full && i_stack_fault_reset_enable
    |=> o_stack_fault_reset && ovf_r && stack_pointer_r == rstack_pkg::SP_EMPTY
    // an empty pop right behind the fault may legally ask for a second reset
    ##1 (!o_stack_fault_reset || $past(pop)))
    else $error("overflow did not raise a one-cycle stack reset");

  unf_flag_a: assert property ( // R6
    pop && is_empty |=> unf_r && (o_stack_fault_reset == $past(i_stack_fault_reset_enable)))
    else $error("empty pop did not flag underflow");

  empty_zero_a: assert property ( // R11
    i_rd && i_addr == rstack_pkg::ADR_TOP_LO && is_empty && i_stack_fault_reset_enable
    |=> o_rdata == 8'h00)
    else $error("empty top read was not zero");

  flag_sticky_a: assert property ( // R15
    ovf_r && !wr_flags |=> ovf_r)
    else $error("overflow flag dropped without a software clear");

  rdata_idle_a: assert property ( // R7
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data present without a read strobe");

  sp_write_a: assert property ( // R7
    wr_sp && !push && !pop |=> stack_pointer_r == $past(i_wdata[4:0]))
    else $error("pointer write not taken");
endmodule

// ==== src/rstack_pkg.sv ====
// constants shared by the return stack and its storage
// assumes one 10 MHz core clock and an 8-bit register port
package rstack_pkg;
  localparam int          DEPTH      = 16;     // stack entries
  localparam int          PC_W       = 15;     // program counter width
  localparam int          LO_W       = 8;      // low byte of an entry
  localparam int          HI_W       = 7;      // high part of an entry
  localparam int          SP_W       = 5;      // pointer keeps one spare state
  localparam int          IDX_W      = 4;      // entry index width
  localparam int          DATA_W     = 8;      // register port data width
  localparam int          ADDR_W     = 8;      // register port address width
  localparam logic [4:0]  SP_EMPTY   = 5'h1f;  // one below entry zero
  localparam logic [4:0]  SP_FULL    = 5'h0f;  // highest entry in use
  localparam logic [4:0]  SP_ONE     = 5'h01;
  localparam logic [3:0]  IDX_ONE    = 4'h1;
  localparam logic [7:0]  ADR_SP     = 8'h0d;  // stack_pointer
  localparam logic [7:0]  ADR_TOP_LO = 8'h0e;  // stack_top_low
  localparam logic [7:0]  ADR_TOP_HI = 8'h0f;  // stack_top_high
  localparam logic [7:0]  ADR_STATUS = 8'h10;  // power_control_status
  localparam int          OVF_BIT    = 7;      // stack_overflow_flag
  localparam int          UNF_BIT    = 6;      // stack_underflow_flag
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [14:0] PC_ZERO    = 15'h0000;
endpackage

// ==== src/stack_mem.sv ====
// return stack storage: one write port with byte lanes, one read port
// assumes the caller never writes two different entries in one cycle
`timescale 1ns/1ns
module stack_mem #(
  parameter int DEPTH = rstack_pkg::DEPTH,
  parameter int WIDTH = rstack_pkg::PC_W,
  parameter int LO_W  = rstack_pkg::LO_W,
  parameter int IDX_W = rstack_pkg::IDX_W
) (
  input  wire logic             i_mclk,
  input  wire logic             i_wr_lo,
  input  wire logic             i_wr_hi,
  input  wire logic [IDX_W-1:0] i_wr_idx,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic [IDX_W-1:0] i_rd_idx,
  output logic      [WIDTH-1:0] o_rd_data
);
  // entries hold no reset: contents after reset are undefined
  logic [WIDTH-1:0] mem_r [DEPTH];

  // byte-lane write, kept apart from code and data storage
  always_ff @(posedge i_mclk) begin
    if (i_wr_lo) begin
      mem_r[i_wr_idx][LO_W-1:0] <= i_wr_data[LO_W-1:0];
    end
    if (i_wr_hi) begin
      mem_r[i_wr_idx][WIDTH-1:LO_W] <= i_wr_data[WIDTH-1:LO_W];
    end
  end

  // read is combinational so a return sees the entry without delay
  assign o_rd_data = mem_r[i_rd_idx];
endmodule

// ==== test/seq_model.sv ====
// sequencer model: pulses push and pop requests toward the stack
// assumes the stack takes a request on the rising edge of i_mclk
`timescale 1ns/1ns
module seq_model (
  input  wire logic        i_mclk,
  output logic      [2:0]  o_push,
  output logic      [2:0]  o_pop,
  output logic      [14:0] o_pc
);
  // idle at time zero, nothing requested
  initial begin
    o_push = 3'h0;
    o_pop  = 3'h0;
    o_pc   = 15'h5555;
  end

  // one-cycle push; pc inverted afterwards so a stale value never matches
  task automatic push(input int k, input logic [14:0] v);
    @(posedge i_mclk);
    o_push[k] <= 1'b1;
    o_pc      <= v;
    @(posedge i_mclk);
    o_push[k] <= 1'b0;
    o_pc      <= ~v;
  endtask

  // one-cycle pop; the pointer is never moved by the bench while a request is out
  task automatic pop(input int k);
    @(posedge i_mclk);
    o_pop[k] <= 1'b1;
    @(posedge i_mclk);
    o_pop[k] <= 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the return stack with a sequencer model
// assumes a 10 MHz clock and the register offsets of the stack package
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [2:0]  push;
  logic [2:0]  pop;
  logic [14:0] pc;
  logic [7:0]  rdata;
  logic [14:0] ret_pc;
  logic        ret_valid;
  logic        fault;
  int          fail_count = 0;
  int          comparisons = 0;
  int          faults = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  seq_model seq (.i_mclk(clk), .o_push(push), .o_pop(pop), .o_pc(pc));

  hardware_return_stack uut (
    .i_mclk(clk), .i_rst(rst), .i_stack_fault_reset_enable(en),
    .i_call(push[0]), .i_call_via_w(push[1]), .i_int_vector(push[2]), .i_pc(pc),
    .i_return(pop[0]), .i_return_with_literal(pop[1]), .i_return_from_interrupt(pop[2]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_ret_pc(ret_pc), .o_ret_valid(ret_valid), .o_stack_fault_reset(fault)
  );

  // fault pulses are counted here; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (fault === 1'b1) faults++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // register port cycles: one strobe cycle, read data only in the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), {7'h00, rdata}, {7'h00, e});
  endtask

  task automatic popc(input int k, input logic v, input logic [14:0] e);
    seq.pop(k);
    #1 chk("ret_valid", {14'h0, ret_valid}, {14'h0, v});
    if (v) chk("ret_pc", ret_pc, e);
  endtask

  task automatic rstx(input logic e);
    @(posedge clk);
    rst <= 1'b1;
    en  <= e;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // empty after reset; top reads zero with fault reset on
  task automatic t_reset();
    rdc(rstack_pkg::ADR_SP, 8'h1f);
    rdc(rstack_pkg::ADR_STATUS, 8'h00);
    rdc(rstack_pkg::ADR_TOP_LO, 8'h00);
    rdc(rstack_pkg::ADR_TOP_HI, 8'h00);
    rdc(8'h11, 8'h00);
  endtask

  // every push kind, then every pop kind, in last-in first-out order
  task automatic t_push_pop();
    seq.push(0, 15'h1234);
    seq.push(1, 15'h2a5b);
    seq.push(2, 15'h7fff);
    rdc(rstack_pkg::ADR_SP, 8'h02);
    rdc(rstack_pkg::ADR_TOP_LO, 8'hff);
    rdc(rstack_pkg::ADR_TOP_HI, 8'h7f);
    popc(2, 1'b1, 15'h7fff);
    popc(1, 1'b1, 15'h2a5b);
    popc(0, 1'b1, 15'h1234);
    rdc(rstack_pkg::ADR_SP, 8'h1f);
  endtask

  // fault reset off: seventeenth push lands in entry zero
  task automatic t_wrap();
    rstx(1'b0);
    faults = 0;
    for (int i = 0; i < 17; i++) seq.push(0, 15'h0100 + 15'(i));
    rdc(rstack_pkg::ADR_SP, 8'h00);
    rdc(rstack_pkg::ADR_TOP_LO, 8'h10);
    rdc(rstack_pkg::ADR_STATUS, 8'h80);
    popc(0, 1'b1, 15'h0110);
    rdc(rstack_pkg::ADR_TOP_LO, 8'h0f);
    popc(1, 1'b1, 15'h010f);
    rdc(rstack_pkg::ADR_SP, 8'h0e);
    rdc(rstack_pkg::ADR_STATUS, 8'hc0);
    chk("faults", 15'(faults), 15'h0);
  endtask

  // fault reset on: overflow and underflow ask for reset, flags persist
  task automatic t_fault();
    rstx(1'b1);
    rdc(rstack_pkg::ADR_STATUS, 8'h00);
    faults = 0;
    for (int i = 0; i < 17; i++) seq.push(2, 15'h0200 + 15'(i));
    rdc(rstack_pkg::ADR_SP, 8'h1f);
    chk("faults", 15'(faults), 15'h1);
    // writing ones keeps the flags; only a zero clears
    wr(rstack_pkg::ADR_STATUS, 8'hc0);
    rdc(rstack_pkg::ADR_STATUS, 8'h80);
    wr(rstack_pkg::ADR_STATUS, 8'h00);
    popc(2, 1'b0, 15'h0);
    rdc(rstack_pkg::ADR_STATUS, 8'h40);
    chk("faults", 15'(faults), 15'h2);
  endtask

  // pointer write selects an entry seen and changed through the top bytes
  task automatic t_ptr();
    wr(rstack_pkg::ADR_SP, 8'h03);
    wr(rstack_pkg::ADR_TOP_LO, 8'h5a);
    wr(rstack_pkg::ADR_TOP_HI, 8'h21);
    rdc(rstack_pkg::ADR_TOP_LO, 8'h5a);
    rdc(rstack_pkg::ADR_TOP_HI, 8'h21);
    popc(1, 1'b1, 15'h215a);
    rdc(rstack_pkg::ADR_SP, 8'h02);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_push_pop();
    t_wrap();
    t_fault();
    t_ptr();
    summarize();
  end
endmodule
